// ### logic/cfa_defines.svh
// constants of the converter fault aggregator: register offsets, field
// positions, reset values and widths; assumes nothing of its surroundings
`ifndef CFA_DEFINES_SVH
`define CFA_DEFINES_SVH

// register offsets on the configuration port
`define CFA_ADDR_W            12
`define CFA_ADDR_SUMMARY      12'h2c0
`define CFA_ADDR_STATUS       12'h2c1
`define CFA_ADDR_MASK         12'h2c2
`define CFA_ADDR_LANES        12'h2c4

// fault bit positions, shared by status and mask, and the summary read bit
`define CFA_BIT_LANE_BUF      5
`define CFA_BIT_PLL           4
`define CFA_BIT_LINK          3
`define CFA_BIT_REALIGN       2
`define CFA_BIT_RSVD          1
`define CFA_BIT_DIVIDER       0
`define CFA_BIT_SUMMARY       0

// reset values
`define CFA_STATUS_RESET      8'h3f
`define CFA_MASK_RESET        8'h3f
`define CFA_SUMMARY_RESET     8'h00
`define CFA_LANES_RESET       8'hff

// status bits that can raise the summary, and bits that hold storage
`define CFA_FAULT_BITS        8'h3d
`define CFA_STATUS_STORE      8'h3f

// widths
`define CFA_LANES             8
`define CFA_DIV_W             4

`endif

// ### logic/cfa_pkg.sv
// types of the converter fault aggregator
// assumes cfa_defines.svh is on the include path
`include "cfa_defines.svh"

package cfa_pkg;

	typedef enum logic {
		CFA_LINK_8B10B,
		CFA_LINK_64B66B
	} cfa_link_mode_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] mask;
		logic       summary;
		logic       pin;
		logic [7:0] rdata;
		logic       rvalid;
		logic       link_en_d;
	} cfa_state_t;

	typedef struct packed {
		logic [`CFA_LANES-1:0] faults;
	} cfa_lane_state_t;

endpackage

// ### logic/cfa_lane_faults.sv
// per-lane buffer fault record, one sticky bit per lane
// assumes lane errors and writes are synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "cfa_defines.svh"

module cfa_lane_faults
	import cfa_pkg::*;
(
	// clock and resets
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  soft_reset,
	// lane events, already qualified by the active lanes
	input  wire logic [`CFA_LANES-1:0] lane_err,
	// software clears
	input  wire logic                  wr_lanes,
	input  wire logic [7:0]            wdata,
	input  wire logic                  clear_all,
	// recorded faults
	output logic      [`CFA_LANES-1:0] faults
);

	cfa_lane_state_t st;
	cfa_lane_state_t st_next;

	always_comb begin
		st_next = st;
		// a clear in the same cycle as a new error loses to the error
		if (clear_all) begin
			st_next.faults = '0; // RQ15
		end else if (wr_lanes) begin
			st_next.faults = st.faults & ~wdata[`CFA_LANES-1:0];
		end
		st_next.faults = st_next.faults | lane_err; // RQ15
		if (soft_reset) begin
			st_next.faults = `CFA_LANES_RESET;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st.faults <= `CFA_LANES_RESET;
		end else begin
			st <= st_next;
		end
	end

	assign faults = st.faults;

	lane_record_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ15
		!soft_reset && (lane_err != '0) |=> (faults & $past(lane_err)) == $past(lane_err))
		else $error("lane error not recorded");

endmodule
`default_nettype wire

// ### logic/cfa_fault_aggregator.sv
// fault collection of the converter: sticky status, mask, summary and
// the calibration status pin route, reached over the configuration port
// assumes all inputs synchronous to clock and a decoded register port
// Notes on behaviour
// RQ1: summary reads 1 when any latched fault is unmasked, else 0.
// RQ2: summary drives calibration status pin when its source select picks it.
// RQ3: lane buffer overflow or underflow on an active lane sets status bit 5.
// RQ4: serializer PLL out of lock sets status bit 4.
// RQ5: 8b/10b: link enabled but not in data state sets bit 3.
// RQ6: 64b/66b: link start or any realignment sets bit 3.
// RQ7: SYSREF realignment of internal clocks sets status bit 2.
// RQ8: divider state mismatch between channel pairs sets status bit 0.
// RQ9: status bits are sticky; writing 1 clears, writing 0 keeps.
// RQ10: power-on and soft reset load status with 0x3F.
// RQ11: with link disabled only the divider fault bit is meaningful.
// RQ12: host should clear faults after enabling the link.
// RQ13: mask bits match status positions, reset 0x3F, set mask hides fault.
// RQ14: host writes reserved mask bits with their defaults.
// RQ15: per-lane register records lane faults; clearing bit 5 clears all lanes.
// RQ16: host waits for initialization done before port transactions.
// RQ17: summary recomputed every cycle; clears and mask writes act next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cfa_defines.svh"

module cfa_fault_aggregator
	import cfa_pkg::*;
(
	// clock and resets
	input  wire logic                   clock,
	input  wire logic                   reset_n,
	input  wire logic                   soft_reset,
	// register port from the configuration serial decoder
	input  wire logic [`CFA_ADDR_W-1:0] reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [7:0]             reg_wdata,
	output logic      [7:0]             reg_rdata,
	output logic                        reg_rvalid,
	// lane buffers
	input  wire logic [`CFA_LANES-1:0]  lane_active,
	input  wire logic [`CFA_LANES-1:0]  lane_fifo_err,
	// serializer and link
	input  wire logic                   serdes_pll_locked,
	input  wire logic                   link_enable,
	input  wire logic                   link_mode_64b66b,
	input  wire logic                   link_data_state,
	input  wire logic                   link_realign,
	// clocking
	input  wire logic                   sysref_realign,
	input  wire logic [`CFA_DIV_W-1:0]  div_state_ab,
	input  wire logic [`CFA_DIV_W-1:0]  div_state_cd,
	// calibration status pin
	input  wire logic                   cal_status_sel_fault,
	input  wire logic                   cal_status_other,
	output logic                        cal_status_pin
);

	cfa_state_t            st;
	cfa_state_t            st_next;
	logic [7:0]            fault_set;
	logic [`CFA_LANES-1:0] lane_err;
	logic [`CFA_LANES-1:0] lane_faults;
	logic                  wr_status;
	logic                  wr_mask;
	logic                  wr_lanes;
	logic                  clear_lanes;
	cfa_link_mode_t        link_mode;

	// one decode used for every register access
	function automatic logic hit(input logic [`CFA_ADDR_W-1:0] addr,
		input logic [`CFA_ADDR_W-1:0] target);
		hit = (addr == target);
	endfunction

	// unmasked faults of a status and mask pair
	function automatic logic any_unmasked(input logic [7:0] status,
		input logic [7:0] mask);
		any_unmasked = |(status & ~mask & `CFA_FAULT_BITS);
	endfunction

	assign link_mode   = link_mode_64b66b ? CFA_LINK_64B66B : CFA_LINK_8B10B;
	assign lane_err    = lane_fifo_err & lane_active;
	assign wr_status   = reg_wr && hit(reg_addr, `CFA_ADDR_STATUS);
	assign wr_mask     = reg_wr && hit(reg_addr, `CFA_ADDR_MASK);
	assign wr_lanes    = reg_wr && hit(reg_addr, `CFA_ADDR_LANES);
	assign clear_lanes = wr_status && reg_wdata[`CFA_BIT_LANE_BUF]; // RQ15

	// fault sources seen in this cycle
	always_comb begin
		fault_set = '0;
		fault_set[`CFA_BIT_LANE_BUF] = |lane_err; // RQ3
		fault_set[`CFA_BIT_PLL] = !serdes_pll_locked; // RQ4
		unique case (link_mode)
			CFA_LINK_8B10B: begin
				fault_set[`CFA_BIT_LINK] = link_enable && !link_data_state; // RQ5
			end
			CFA_LINK_64B66B: begin
				// no data state exists here, so only start and realignments count
				fault_set[`CFA_BIT_LINK] = (link_enable && !st.link_en_d) || link_realign; // RQ6
			end
		endcase
		fault_set[`CFA_BIT_REALIGN] = sysref_realign; // RQ7
		// the divider compare ignores the link enable, so this bit stays meaningful with the link off
		fault_set[`CFA_BIT_DIVIDER] = (div_state_ab != div_state_cd); // RQ8 RQ11
	end

	always_comb begin
		st_next = st;
		st_next.link_en_d = link_enable;
		// write-one-to-clear first, then new faults; a fault in the clear cycle wins
		if (wr_status) begin
			st_next.status = st.status & ~reg_wdata; // RQ9
		end
		st_next.status = (st_next.status | fault_set) & `CFA_STATUS_STORE; // RQ9
		if (wr_mask) begin
			// reserved bits are stored as written; keeping defaults is up to the host
			st_next.mask = reg_wdata; // RQ13
		end
		// summary follows the registered status, so it lags a clear by one cycle
		st_next.summary = any_unmasked(st.status, st.mask); // RQ1 RQ17
		st_next.pin = cal_status_sel_fault ? st.summary : cal_status_other; // RQ2
		st_next.rvalid = reg_rd;
		st_next.rdata = '0;
		if (reg_rd) begin
			if (hit(reg_addr, `CFA_ADDR_SUMMARY)) begin
				st_next.rdata[`CFA_BIT_SUMMARY] = st.summary; // RQ1
			end else if (hit(reg_addr, `CFA_ADDR_STATUS)) begin
				st_next.rdata = st.status;
			end else if (hit(reg_addr, `CFA_ADDR_MASK)) begin
				st_next.rdata = st.mask;
			end else if (hit(reg_addr, `CFA_ADDR_LANES)) begin
				st_next.rdata = lane_faults;
			end
		end
		if (soft_reset) begin
			st_next.status  = `CFA_STATUS_RESET; // RQ10
			st_next.mask    = `CFA_MASK_RESET; // RQ13
			st_next.summary = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st.status    <= `CFA_STATUS_RESET; // RQ10
			st.mask      <= `CFA_MASK_RESET; // RQ13
			st.summary   <= 1'b0;
			st.pin       <= 1'b0;
			st.rdata     <= `CFA_SUMMARY_RESET;
			st.rvalid    <= 1'b0;
			st.link_en_d <= 1'b0;
		end else begin
			st <= st_next;
		end
	end

	cfa_lane_faults u_lanes (
		.clock      (clock),
		.reset_n    (reset_n),
		.soft_reset (soft_reset),
		.lane_err   (lane_err),
		.wr_lanes   (wr_lanes),
		.wdata      (reg_wdata),
		.clear_all  (clear_lanes),
		.faults     (lane_faults)
	);

	assign reg_rdata      = st.rdata;
	assign reg_rvalid     = st.rvalid;
	assign cal_status_pin = st.pin;

	summary_follows_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
		!soft_reset && !$past(soft_reset) |->
			st.summary == |($past(st.status) & ~$past(st.mask) & `CFA_FAULT_BITS))
		else $error("summary does not match unmasked faults");

	summary_read_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
		reg_rd && hit(reg_addr, `CFA_ADDR_SUMMARY) |=>
			reg_rvalid && reg_rdata == {7'h00, $past(st.summary)})
		else $error("summary read wrong");

	pin_route_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ2
		cal_status_sel_fault |=> cal_status_pin == $past(st.summary))
		else $error("pin does not carry summary");

	lane_set_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ3
		|(lane_fifo_err & lane_active) |=> st.status[`CFA_BIT_LANE_BUF])
		else $error("lane buffer fault not set");

	pll_set_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ4
		!serdes_pll_locked |=> st.status[`CFA_BIT_PLL])
		else $error("pll fault not set");

	link_8b10b_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ5
		!link_mode_64b66b && link_enable && !link_data_state |=> st.status[`CFA_BIT_LINK])
		else $error("link fault not set in 8b10b");

	link_64b66b_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ6
		link_mode_64b66b && ($rose(link_enable) || link_realign) |=> st.status[`CFA_BIT_LINK])
		else $error("link fault not set in 64b66b");

	realign_set_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ7
		sysref_realign |=> st.status[`CFA_BIT_REALIGN])
		else $error("realign fault not set");

	divider_set_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ8
		div_state_ab != div_state_cd |=> st.status[`CFA_BIT_DIVIDER])
		else $error("divider fault not set");

	status_sticky_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ9
		!wr_status && !soft_reset |=> (st.status & $past(st.status)) == $past(st.status))
		else $error("status bit lost without a clear");

	status_clear_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ9
		wr_status && !soft_reset |=>
			(st.status & $past(reg_wdata) & ~$past(fault_set)) == 8'h00)
		else $error("written one did not clear");

	soft_reset_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ10
		soft_reset |=> st.status == `CFA_STATUS_RESET && st.mask == `CFA_MASK_RESET)
		else $error("soft reset values wrong");

	mask_hides_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ13
		(st.mask & `CFA_FAULT_BITS) == `CFA_FAULT_BITS && !soft_reset |=> !st.summary)
		else $error("masked fault reached summary");

	lane_clear_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ15
		clear_lanes && lane_err == '0 && !soft_reset |=> lane_faults == '0)
		else $error("lane record not cleared");

	mask_write_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ17
		wr_mask && !soft_reset |=> st.mask == $past(reg_wdata) ##1
			st.summary == any_unmasked($past(st.status), $past(st.mask)))
		else $error("mask write did not reach summary");

	// register read-back, reset values and the quiet paths
	reset_values_a: assert property (@(posedge clock) // RQ10
		!reset_n |=> st.status == `CFA_STATUS_RESET && st.mask == `CFA_MASK_RESET && !st.summary)
		else $error("reset values wrong");

	status_reserved_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ10
		st.status[7:6] == 2'b00)
		else $error("reserved status bits set");

	divider_link_off_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ11
		!link_enable && div_state_ab != div_state_cd |=> st.status[`CFA_BIT_DIVIDER])
		else $error("divider fault lost with link off");

	pin_other_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ2
		!cal_status_sel_fault |=> cal_status_pin == $past(cal_status_other))
		else $error("pin does not carry other source");

	status_read_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ9
		reg_rd && hit(reg_addr, `CFA_ADDR_STATUS) |=>
			reg_rvalid && reg_rdata == $past(st.status))
		else $error("status read wrong");

	mask_read_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ13
		reg_rd && hit(reg_addr, `CFA_ADDR_MASK) |=>
			reg_rvalid && reg_rdata == $past(st.mask))
		else $error("mask read wrong");

	lane_read_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ15
		reg_rd && hit(reg_addr, `CFA_ADDR_LANES) |=>
			reg_rvalid && reg_rdata == $past(lane_faults))
		else $error("lane record read wrong");

	mask_keep_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ13
		!wr_mask && !soft_reset |=> st.mask == $past(st.mask))
		else $error("mask changed without a write");

	status_rise_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ9
		!soft_reset |=> (st.status & ~$past(st.status) & ~$past(fault_set)) == 8'h00)
		else $error("status bit set without a fault");

	zero_write_keeps_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ9
		wr_status && !soft_reset |=>
			(st.status & $past(st.status) & ~$past(reg_wdata)) == ($past(st.status) & ~$past(reg_wdata)))
		else $error("written zero lost a status bit");

	summary_raise_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
		(st.status & ~st.mask & `CFA_FAULT_BITS) != 8'h00 && !soft_reset |=> st.summary)
		else $error("unmasked fault missing from summary");

	summary_soft_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ10
		soft_reset |=> !st.summary)
		else $error("summary not cleared by soft reset");

	summary_drop_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ17
		wr_status && reg_wdata == `CFA_STATUS_STORE && fault_set == 8'h00 |=> ##1 !st.summary)
		else $error("summary did not drop after a full clear");

	lane_bit_clear_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ15
		wr_lanes && !soft_reset |=> (lane_faults & $past(reg_wdata) & ~$past(lane_err)) == 8'h00)
		else $error("lane bit not cleared");

	lane_sticky_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ15
		!wr_lanes && !clear_lanes && !soft_reset |=>
			(lane_faults & $past(lane_faults)) == $past(lane_faults))
		else $error("lane fault lost without a clear");

	lane_soft_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ15
		soft_reset |=> lane_faults == `CFA_LANES_RESET)
		else $error("lane record not reset");

endmodule
`default_nettype wire

// ### test/cfa_host_model.sv
// host software model: register writes and reads over the decoded port
// assumes the aggregator samples strobes on the rising edge of clock
`timescale 1ns/1ps
`default_nettype none
`include "cfa_defines.svh"

module cfa_host_model (
	// clock
	input  wire logic                   clock,
	// register port
	output logic      [`CFA_ADDR_W-1:0] reg_addr,
	output logic                        reg_wr,
	output logic                        reg_rd,
	output logic      [7:0]             reg_wdata,
	input  wire logic [7:0]             reg_rdata,
	input  wire logic                   reg_rvalid
);
	initial begin
		{reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
	end

	// strobes move on the falling edge so the rising edge sees them settled
	task automatic wr(input logic [`CFA_ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask

	// read data stands for one cycle only, so it is taken at the next falling edge
	task automatic rd(input logic [`CFA_ADDR_W-1:0] a, output logic [7:0] d, output logic v);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		d = reg_rdata;
		v = reg_rvalid;
		reg_rd = 1'b0;
	endtask

	// reserved mask bits always carry their defaults: 7:6 low, bit 1 high
	task automatic wr_mask(input logic [7:0] hide);
		wr(`CFA_ADDR_MASK, (hide & 8'h3d) | 8'h02);
	endtask
endmodule

`default_nettype wire

// ### test/tb.sv
// testbench of the fault aggregator: fault inputs and host accesses
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cfa_defines.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end

module tb;
	logic                   clock, reset_n, soft_reset;
	logic [`CFA_ADDR_W-1:0] reg_addr;
	logic                   reg_wr, reg_rd, reg_rvalid, cal_status_pin;
	logic [7:0]             reg_wdata, reg_rdata, lane_active, lane_fifo_err;
	logic                   serdes_pll_locked, link_enable, link_mode_64b66b, link_data_state;
	logic                   link_realign, sysref_realign, cal_status_sel_fault, cal_status_other;
	logic [`CFA_DIV_W-1:0]  div_state_ab, div_state_cd;
	logic [7:0]             rd_data;
	logic                   rd_ok;
	int                     error_cnt = 0;
	int                     num_checks = 0;

	cfa_fault_aggregator dut (.clock, .reset_n, .soft_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .reg_rvalid, .lane_active, .lane_fifo_err, .serdes_pll_locked, .link_enable,
		.link_mode_64b66b, .link_data_state, .link_realign, .sysref_realign, .div_state_ab,
		.div_state_cd, .cal_status_sel_fault, .cal_status_other, .cal_status_pin);
	cfa_host_model host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic rchk(input logic [`CFA_ADDR_W-1:0] a, input logic [7:0] ex, input string nm);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		`CHK({nm, " rvalid"}, 1'b1, v)
		`CHK(nm, ex, d)
	endtask

	// fault inputs are already calm again, so the clear must stick
	task automatic bit_chk(input int b, input string nm);
		rchk(`CFA_ADDR_STATUS, 8'h01 << b, nm);
		host.wr(`CFA_ADDR_STATUS, 8'h01 << b);
		rchk(`CFA_ADDR_STATUS, 8'h00, {nm, " cleared"});
	endtask

	task automatic t_reset;
		rchk(`CFA_ADDR_STATUS, 8'h3f, "status");
		rchk(`CFA_ADDR_MASK, 8'h3f, "mask");
		rchk(`CFA_ADDR_SUMMARY, 8'h00, "summary");
		rchk(`CFA_ADDR_LANES, 8'hff, "lanes");
		rchk(12'h2c3, 8'h00, "unmapped");
		$display("test reset done");
	endtask

	task automatic t_clear;
		host.wr(`CFA_ADDR_STATUS, 8'h00);
		rchk(`CFA_ADDR_STATUS, 8'h3f, "status kept");
		host.wr(`CFA_ADDR_STATUS, 8'h3f);
		rchk(`CFA_ADDR_STATUS, 8'h00, "status cleared");
		rchk(`CFA_ADDR_LANES, 8'h00, "lanes cleared");
		$display("test clear done");
	endtask

	task automatic t_sources;
		lane_active = 8'hfb;
		lane_fifo_err = 8'h04;
		@(negedge clock);
		lane_fifo_err = 8'h00;
		rchk(`CFA_ADDR_STATUS, 8'h00, "idle lane");
		lane_active = 8'hff;
		lane_fifo_err = 8'h24;
		@(negedge clock);
		lane_fifo_err = 8'h00;
		rchk(`CFA_ADDR_LANES, 8'h24, "lane record");
		host.wr(`CFA_ADDR_LANES, 8'h04);
		rchk(`CFA_ADDR_LANES, 8'h20, "lane bit cleared");
		bit_chk(5, "lane buffer");
		rchk(`CFA_ADDR_LANES, 8'h00, "lanes by bit5");
		serdes_pll_locked = 1'b0;
		@(negedge clock);
		serdes_pll_locked = 1'b1;
		bit_chk(4, "pll unlock");
		link_data_state = 1'b0;
		@(negedge clock);
		link_data_state = 1'b1;
		bit_chk(3, "link state");
		link_mode_64b66b = 1'b1;
		link_realign = 1'b1;
		@(negedge clock);
		link_realign = 1'b0;
		bit_chk(3, "realign 64b");
		link_enable = 1'b0;
		@(negedge clock);
		link_enable = 1'b1;
		bit_chk(3, "link start");
		link_mode_64b66b = 1'b0;
		sysref_realign = 1'b1;
		@(negedge clock);
		sysref_realign = 1'b0;
		bit_chk(2, "sysref");
		div_state_cd = 4'h3;
		@(negedge clock);
		div_state_cd = 4'h0;
		bit_chk(0, "divider");
		link_enable = 1'b0;
		div_state_ab = 4'h5;
		@(negedge clock);
		div_state_ab = 4'h0;
		host.rd(`CFA_ADDR_STATUS, rd_data, rd_ok);
		`CHK("divider link off", 1'b1, rd_data[0])
		link_enable = 1'b1;
		host.wr(`CFA_ADDR_STATUS, 8'h3f);
		$display("test sources done");
	endtask

	task automatic t_summary;
		host.wr_mask(8'h00);
		rchk(`CFA_ADDR_MASK, 8'h02, "mask open");
		rchk(`CFA_ADDR_SUMMARY, 8'h00, "summary quiet");
		cal_status_sel_fault = 1'b1;
		serdes_pll_locked = 1'b0;
		@(negedge clock);
		serdes_pll_locked = 1'b1;
		rchk(`CFA_ADDR_SUMMARY, 8'h01, "summary");
		`CHK("pin fault", 1'b1, cal_status_pin)
		cal_status_sel_fault = 1'b0;
		@(negedge clock);
		`CHK("pin other low", 1'b0, cal_status_pin)
		cal_status_other = 1'b1;
		cal_status_sel_fault = 1'b1;
		host.wr_mask(8'h10);
		rchk(`CFA_ADDR_SUMMARY, 8'h00, "summary masked");
		`CHK("pin masked", 1'b0, cal_status_pin)
		$display("test summary done");
	endtask

	task automatic t_soft;
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		rchk(`CFA_ADDR_STATUS, 8'h3f, "soft status");
		rchk(`CFA_ADDR_MASK, 8'h3f, "soft mask");
		rchk(`CFA_ADDR_LANES, 8'hff, "soft lanes");
		$display("test soft reset done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		reset_n = 1'b0;
		{soft_reset, lane_fifo_err, link_realign, sysref_realign, link_mode_64b66b} = '0;
		{cal_status_sel_fault, cal_status_other, div_state_ab, div_state_cd} = '0;
		{serdes_pll_locked, link_enable, link_data_state} = 3'b111;
		lane_active = 8'hff;
		repeat (10) @(negedge clock);
		reset_n = 1'b1;
		// this block has no initialization phase, so access may start right after reset
		t_reset;
		t_clear;
		t_sources;
		t_summary;
		t_soft;
		tally_and_finish;
	end

	// the tests need some 120 cycles; this margin only cuts a hang short
	initial begin
		repeat (4000) @(posedge clock);
		error_cnt++;
		tally_and_finish;
	end
endmodule

`default_nettype wire
